// ==== aort_pkg.sv ====
// aort_pkg: shared constants and types for the converter sample-path block
// assumes a single 200 MHz clock domain; nothing is imported by users
package aort_pkg;
	localparam int SAMPLE_W      = 12;
	localparam int THRESH_W      = 8;
	localparam int HOLD_SEL_W    = 3;
	localparam int TRIG_SEL_W    = 2;
	localparam int HOLD_CNT_W    = 11;
	localparam int HOLD_BASE     = 8;
	localparam int CMP_LSB       = 3;
	localparam int FIFO_DEPTH    = 16;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SYNC_STAGES   = 2;
	localparam logic [TRIG_SEL_W-1:0] TRIG_SEL_MARK = 2'h3;
	localparam logic [SAMPLE_W-1:0]   CODE_MIN      = 12'h800;
	localparam logic [SAMPLE_W-1:0]   CODE_MAX      = 12'h7FF;

	typedef struct packed {
		logic [SAMPLE_W-1:0] data;
		logic                mark;
	} aort_sample_t;

	typedef struct packed {
		logic [THRESH_W-1:0]   threshold;
		logic                  detect_enable;
		logic [HOLD_SEL_W-1:0] hold_select;
	} aort_ovr_cfg_t;
endpackage

// ==== aort_fifo.sv ====
// aort_fifo: synchronous valid/ready FIFO in the link sample path
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module aort_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             rst_in,
	// write side
	input  wire logic             wr_valid_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	output logic                  wr_ready_out,
	// read side
	output logic                  rd_valid_out,
	output logic [WIDTH-1:0]      rd_data_out,
	input  wire logic             rd_ready_in
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             do_wr;
	logic             do_rd;

	assign wr_ready_out = (count != DEPTH[AW:0]);
	assign rd_valid_out = (count != '0);
	assign rd_data_out  = mem[rd_ptr];

	always_comb
	begin
		do_wr       = wr_valid_in && wr_ready_out;
		do_rd       = rd_valid_out && rd_ready_in;
		next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
		next_count  = count;
		if (do_wr && !do_rd)
			next_count = count + 1'b1;
		else if (do_rd && !do_wr)
			next_count = count - 1'b1;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// storage carries no reset; only the occupancy count defines validity
	always_ff @(posedge clk_sys_in)
	begin
		if (do_wr)
			mem[wr_ptr] <= wr_data_in;
	end
endmodule

// ==== aort_sample_path.sv ====
// aort_sample_path: sample coding, over-range flags, time mark and link word
// assumes samples arrive one per clock from the converter core on clk_sys_in
`timescale 1ns/1ps
//Behaviour
//- take one converted sample per rising clock edge
//- samples are signed two's complement, sign follows input difference
//- codes span -2048 to +2047
//- compare upper eight bits of sample magnitude against threshold
//- magnitude of -2048 saturates to 2047, upper bits 255
//- one threshold serves every channel
//- detection only while detect enable is one
//- flag is one when upper bits reach threshold, else zero
//- one flag output per channel
//- flag holds 8 doubling to 1024 cycles after last event
//- time mark input is retimed to the sampling clock
//- trigger repeats mark only when enabled and select equals three
//- mark rides the link only when time-stamp enable is set
//- mark replaces sample bit 0, sample truncated into bits 11:1
//- mark lags samples taken at the same edge by three cycles
//- time-stamp feature idle while mark receiver disabled
//- full-scale setting is common to all inputs
module aort_sample_path #(
	parameter int CHANNELS = 4,
	parameter int FS_W     = 8
) (
	// clock and reset
	input  wire logic                                   clk_sys_in,
	input  wire logic                                   rst_in,
	// converter core samples, one per channel
	input  wire logic [CHANNELS*aort_pkg::SAMPLE_W-1:0] sample_in,
	input  wire logic                                   sample_valid_in,
	// over-range configuration
	input  wire aort_pkg::aort_ovr_cfg_t                ovr_cfg_in,
	// time mark and trigger configuration
	input  wire logic                                   time_mark_input_in,
	input  wire logic                                   time_mark_receiver_enable_in,
	input  wire logic                                   time_stamp_enable_in,
	input  wire logic                                   trigger_output_enable_in,
	input  wire logic [aort_pkg::TRIG_SEL_W-1:0]        trigger_output_select_in,
	// full-scale setting, shared by all inputs
	input  wire logic [FS_W-1:0]                        full_scale_setting_in,
	output logic [FS_W-1:0]                             full_scale_setting_out,
	// over-range flags
	output logic [CHANNELS-1:0]                         overrange_flag_out,
	// trigger output
	output logic                                        trigger_output_out,
	// link samples
	output logic [CHANNELS*aort_pkg::SAMPLE_W-1:0]      link_data_out,
	output logic                                        link_valid_out,
	input  wire logic                                   link_ready_in,
	// back-pressure and overflow status
	output logic                                        sample_ready_out,
	output logic                                        sample_drop_out
);
	localparam int SW = aort_pkg::SAMPLE_W;
	localparam int LW = CHANNELS * SW;

	// upper eight bits of saturated magnitude
	function automatic logic [aort_pkg::THRESH_W-1:0] mag_upper(input logic [SW-1:0] s);
		logic [SW-1:0] m;
		m = '0;
		if (s == aort_pkg::CODE_MIN)
			m = aort_pkg::CODE_MAX;
		else if (s[SW-1])
			m = SW'(-s);
		else
			m = s;
		return m[aort_pkg::CMP_LSB +: aort_pkg::THRESH_W];
	endfunction

	// hold length 8 << select
	function automatic logic [aort_pkg::HOLD_CNT_W-1:0] hold_len(
		input logic [aort_pkg::HOLD_SEL_W-1:0] sel);
		return aort_pkg::HOLD_CNT_W'(aort_pkg::HOLD_BASE) << sel;
	endfunction

	// mark synchroniser: first stage read only by second
	logic [aort_pkg::SYNC_STAGES-1:0] mark_sync;
	logic [aort_pkg::SYNC_STAGES-1:0] next_mark_sync;
	logic                             mark_rt;
	logic                             next_mark_rt;

	always_comb
	begin
		next_mark_sync = {mark_sync[0], time_mark_input_in};
		next_mark_rt   = mark_sync[1] && time_mark_receiver_enable_in;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			mark_sync <= '0;
			mark_rt   <= 1'b0;
		end
		else
		begin
			mark_sync <= next_mark_sync;
			mark_rt   <= next_mark_rt;
		end
	end

	// captured sample stage, mark sampled alongside
	aort_pkg::aort_sample_t        cap [CHANNELS];
	aort_pkg::aort_sample_t        next_cap [CHANNELS];
	logic                          cap_valid;
	logic                          next_cap_valid;

	always_comb
	begin
		next_cap_valid = sample_valid_in;
		for (int c = 0; c < CHANNELS; c++)
		begin
			next_cap[c].data = sample_in[c*SW +: SW];
			next_cap[c].mark = mark_rt;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			cap_valid <= 1'b0;
			for (int c = 0; c < CHANNELS; c++)
				cap[c] <= '0;
		end
		else
		begin
			cap_valid <= next_cap_valid;
			for (int c = 0; c < CHANNELS; c++)
				cap[c] <= next_cap[c];
		end
	end

	// over-range hold counters, one per channel
	logic [aort_pkg::HOLD_CNT_W-1:0] hold_cnt [CHANNELS];
	logic [aort_pkg::HOLD_CNT_W-1:0] next_hold_cnt [CHANNELS];
	logic [CHANNELS-1:0]             next_flag;
	logic                            hit;

	always_comb
	begin
		hit = 1'b0;
		for (int c = 0; c < CHANNELS; c++)
		begin
			// same threshold for every channel
			hit = cap_valid && ovr_cfg_in.detect_enable
				&& (mag_upper(cap[c].data) >= ovr_cfg_in.threshold);
			if (!ovr_cfg_in.detect_enable)
				next_hold_cnt[c] = '0;
			else if (hit)
				next_hold_cnt[c] = hold_len(ovr_cfg_in.hold_select);
			else if (hold_cnt[c] != '0)
				next_hold_cnt[c] = hold_cnt[c] - 1'b1;
			else
				next_hold_cnt[c] = '0;
			next_flag[c] = (next_hold_cnt[c] != '0);
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			overrange_flag_out <= '0;
			for (int c = 0; c < CHANNELS; c++)
				hold_cnt[c] <= '0;
		end
		else
		begin
			overrange_flag_out <= next_flag;
			for (int c = 0; c < CHANNELS; c++)
				hold_cnt[c] <= next_hold_cnt[c];
		end
	end

	// link word assembly and trigger repeat
	logic [LW-1:0] link_word;
	logic          next_trig;
	logic [FS_W-1:0] next_fs;

	always_comb
	begin
		for (int c = 0; c < CHANNELS; c++)
		begin
			if (time_stamp_enable_in && time_mark_receiver_enable_in)
				link_word[c*SW +: SW] = {cap[c].data[SW-1:1], cap[c].mark};
			else
				link_word[c*SW +: SW] = cap[c].data;
		end
		next_trig = mark_rt && trigger_output_enable_in
			&& (trigger_output_select_in == aort_pkg::TRIG_SEL_MARK);
		next_fs = full_scale_setting_in;
	end

	// drop flag is sticky until reset; a set loses only to reset in the same cycle
	logic fifo_wr_ready;
	logic next_drop;

	always_comb
	begin
		next_drop = sample_drop_out || (cap_valid && !fifo_wr_ready);
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			trigger_output_out     <= 1'b0;
			full_scale_setting_out <= '0;
			sample_drop_out        <= 1'b0;
			sample_ready_out       <= 1'b0;
		end
		else
		begin
			trigger_output_out     <= next_trig;
			full_scale_setting_out <= next_fs;
			sample_drop_out        <= next_drop;
			sample_ready_out       <= fifo_wr_ready;
		end
	end

	// fifo output registered so ports come from flops
	logic          fifo_rd_valid;
	logic [LW-1:0] fifo_rd_data;
	logic          fifo_rd_ready;
	logic          next_link_valid;
	logic [LW-1:0] next_link_data;

	always_comb
	begin
		fifo_rd_ready   = !link_valid_out || link_ready_in;
		next_link_valid = link_valid_out && !link_ready_in;
		next_link_data  = link_data_out;
		if (fifo_rd_ready && fifo_rd_valid)
		begin
			next_link_valid = 1'b1;
			next_link_data  = fifo_rd_data;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			link_valid_out <= 1'b0;
			link_data_out  <= '0;
		end
		else
		begin
			link_valid_out <= next_link_valid;
			link_data_out  <= next_link_data;
		end
	end

	// converter cannot pause, so a full fifo drops and flags it
	aort_fifo #(
		.WIDTH (LW),
		.DEPTH (aort_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys_in   (clk_sys_in),
		.rst_in       (rst_in),
		.wr_valid_in  (cap_valid),
		.wr_data_in   (link_word),
		.wr_ready_out (fifo_wr_ready),
		.rd_valid_out (fifo_rd_valid),
		.rd_data_out  (fifo_rd_data),
		.rd_ready_in  (fifo_rd_ready)
	);
endmodule

// ==== aort_link_sink.sv ====
// aort_link_sink: downstream receiver of link words, can stall
// assumes stall_in changes at falling edges, one clock
`timescale 1ns/1ps
module aort_link_sink #(
	parameter int W = 48
) (
	// clock and reset
	input	wire logic		clk_sys_in,
	input	wire logic		rst_in,
	// link side
	input	wire logic		stall_in,
	input	wire logic		valid_in,
	input	wire logic [W-1:0]	data_in,
	output	logic			ready_out
);
	logic [W-1:0] words[$];
	// never ready in reset, so no word is taken early
	assign ready_out = !rst_in && !stall_in;
	always @(posedge clk_sys_in)
	begin
		if (valid_in && ready_out)
		begin
			words.push_back(data_in);
		end
	end
endmodule

// ==== aort_sample_path_chk.sv ====
// aort_sample_path_chk: port assertions for the sample path
// assumes a bind to aort_sample_path, one clock domain
`timescale 1ns/1ps
module aort_sample_path_chk #(
	parameter int CHANNELS = 4,
	parameter int FS_W = 8
) (
	// clock and reset
	input	wire logic				clk_sys_in,
	input	wire logic				rst_in,
	// inputs
	input	wire logic				sample_valid_in,
	input	wire aort_pkg::aort_ovr_cfg_t		ovr_cfg_in,
	input	wire logic				time_mark_receiver_enable_in,
	input	wire logic				trigger_output_enable_in,
	input	wire logic [aort_pkg::TRIG_SEL_W-1:0]	trigger_output_select_in,
	input	wire logic [FS_W-1:0]			full_scale_setting_in,
	input	wire logic				link_ready_in,
	// outputs
	input	wire logic [FS_W-1:0]			full_scale_setting_out,
	input	wire logic [CHANNELS-1:0]		overrange_flag_out,
	input	wire logic				trigger_output_out,
	input	wire logic [CHANNELS*12-1:0]		link_data_out,
	input	wire logic				link_valid_out,
	input	wire logic				sample_ready_out,
	input	wire logic				sample_drop_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	fs_copy_a:
		assert property (!$past(rst_in) |-> full_scale_setting_out == $past(full_scale_setting_in))
		else $error("full scale copy wrong");
	trig_gate_a:
		assert property (trigger_output_out |-> $past(trigger_output_enable_in)
			&& $past(trigger_output_select_in) == aort_pkg::TRIG_SEL_MARK)
		else $error("trigger without enable and select");
	trig_recv_a:
		assert property (trigger_output_out |-> $past(time_mark_receiver_enable_in, 2))
		else $error("trigger with receiver off");
	ovr_off_a:
		assert property ((!ovr_cfg_in.detect_enable) [*3] |-> overrange_flag_out == '0)
		else $error("flag while detection off");
	flag_hold_a:
		assert property ($rose(overrange_flag_out[0])
			|-> (overrange_flag_out[0] || !ovr_cfg_in.detect_enable) [*8])
		else $error("flag shorter than hold");
	valid_lat_a:
		assert property (sample_valid_in && sample_ready_out |-> ##3 link_valid_out)
		else $error("link word late");
	link_hold_a:
		assert property (link_valid_out && !link_ready_in |=> link_valid_out && $stable(link_data_out))
		else $error("link word changed while stalled");
	drop_stick_a:
		assert property (sample_drop_out |=> sample_drop_out)
		else $error("drop flag cleared");
	cover property ($rose(overrange_flag_out[0]));
	cover property ($rose(trigger_output_out));
	cover property ($rose(sample_drop_out));
endmodule
bind aort_sample_path aort_sample_path_chk #(.CHANNELS(CHANNELS), .FS_W(FS_W)) chk_inst (
	.clk_sys_in, .rst_in, .sample_valid_in, .ovr_cfg_in, .time_mark_receiver_enable_in,
	.trigger_output_enable_in, .trigger_output_select_in, .full_scale_setting_in,
	.link_ready_in, .full_scale_setting_out, .overrange_flag_out, .trigger_output_out,
	.link_data_out, .link_valid_out, .sample_ready_out, .sample_drop_out
);

// ==== test_aort_sample_path.sv ====
// test_aort_sample_path: directed bench for the sample path
// assumes aort_link_sink as the downstream receiver
`timescale 1ns/1ps
module test_aort_sample_path;
	// stimulus
	logic				clk_sys_in = 1'b0;
	logic				rst_in = 1'b1;
	logic [47:0]			sample_in = 48'h0;
	logic				sample_valid_in = 1'b0;
	aort_pkg::aort_ovr_cfg_t	ovr_cfg_in = '0;
	logic				time_mark_input_in = 1'b0;
	logic				time_mark_receiver_enable_in = 1'b0;
	logic				time_stamp_enable_in = 1'b0;
	logic				trigger_output_enable_in = 1'b0;
	logic [1:0]			trigger_output_select_in = 2'h0;
	logic [7:0]			full_scale_setting_in = 8'hA5;
	logic				stall = 1'b0;
	// observed
	logic [7:0]			full_scale_setting_out;
	logic [3:0]			overrange_flag_out;
	logic [47:0]			link_data_out;
	logic				trigger_output_out, link_valid_out, link_ready_in;
	logic				sample_ready_out, sample_drop_out;
	// bookkeeping
	int				mismatches = 0;
	int				n_checks = 0;
	int				n;
	logic [2:0]			cfg [4] = '{3'h7, 3'h6, 3'h3, 3'h5};
	aort_sample_path #(.CHANNELS(4), .FS_W(8)) aort_sample_path_inst (
		.clk_sys_in, .rst_in, .sample_in, .sample_valid_in, .ovr_cfg_in,
		.time_mark_input_in, .time_mark_receiver_enable_in, .time_stamp_enable_in,
		.trigger_output_enable_in, .trigger_output_select_in, .full_scale_setting_in,
		.full_scale_setting_out, .overrange_flag_out, .trigger_output_out, .link_data_out,
		.link_valid_out, .link_ready_in, .sample_ready_out, .sample_drop_out
	);
	aort_link_sink aort_link_sink_inst (
		.clk_sys_in, .rst_in, .stall_in(stall), .valid_in(link_valid_out),
		.data_in(link_data_out), .ready_out(link_ready_in)
	);
	initial forever #2.5 clk_sys_in = ~clk_sys_in;
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// caller lowers valid after the last word, so valid is never set twice at one edge
	task automatic put(input logic [47:0] s);
		sample_in = s;
		sample_valid_in = 1'b1;
		@(negedge clk_sys_in);
	endtask
	function automatic logic [47:0] lw(input logic [47:0] s, input logic ins, input logic m);
		lw = s;
		for (int c = 0; c < 4; c++)
		begin
			lw[12*c] = ins ? m : s[12*c];
		end
	endfunction
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
		begin
			$display("Testbench passed");
		end
		else
		begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial
	begin
		#20us;
		mismatches++;
		give_verdict();
	end
	initial
	begin
		repeat (6) @(negedge clk_sys_in);
		rst_in = 1'b0;
		@(negedge clk_sys_in);
		chk("full scale", 48'hA5, full_scale_setting_out);
		chk("ready idle", 48'h1, 48'(sample_ready_out));
		// mark pin set with the enables, six cycles before the sample
		for (int i = 0; i < 4; i++)
		begin
			{time_stamp_enable_in, time_mark_receiver_enable_in, time_mark_input_in} = cfg[i];
			repeat (6) @(negedge clk_sys_in);
			aort_link_sink_inst.words.delete();
			put(48'h7FF_800_001_FFE);
			sample_valid_in = 1'b0;
			repeat (4) @(negedge clk_sys_in);
			n = aort_link_sink_inst.words.size();
			chk("word count", 48'h1, 48'(n));
			chk("link word", lw(48'h7FF_800_001_FFE, cfg[i][2] & cfg[i][1], cfg[i][0]),
				n > 0 ? aort_link_sink_inst.words[0] : 'x);
		end
		time_mark_input_in = 1'b1;
		for (int k = 0; k < 9; k++)
		begin
			time_mark_receiver_enable_in = k < 8;
			{trigger_output_enable_in, trigger_output_select_in} = k < 8 ? 3'(k) : 3'h7;
			repeat (6) @(negedge clk_sys_in);
			chk("trigger", 48'(k == 7), 48'(trigger_output_out));
		end
		// threshold 228 sits near full scale, as the receiver would set it
		for (int sel = 0; sel < 8; sel += 3)
		begin
			ovr_cfg_in = {8'hE4, 1'b1, 3'(sel)};
			put(48'h8E0_718_7FF_800);
			sample_valid_in = 1'b0;
			// flag rises one cycle after capture; count from its first high cycle
			repeat (1) @(negedge clk_sys_in);
			chk("flags", 48'hB, 48'(overrange_flag_out));
			n = 0;
			while (overrange_flag_out[0] === 1'b1 && n < 2000)
			begin
				n++;
				@(negedge clk_sys_in);
			end
			chk("hold", 48'(8 << sel), 48'(n));
		end
		ovr_cfg_in.detect_enable = 1'b0;
		put(48'h800_800_800_800);
		sample_valid_in = 1'b0;
		repeat (3) @(negedge clk_sys_in);
		chk("flags off", 48'h0, 48'(overrange_flag_out));
		stall = 1'b1;
		aort_link_sink_inst.words.delete();
		repeat (24) put(48'h123_456_789_ABC);
		sample_valid_in = 1'b0;
		repeat (2) @(negedge clk_sys_in);
		chk("drop", 48'h1, 48'(sample_drop_out));
		chk("ready", 48'h0, 48'(sample_ready_out));
		stall = 1'b0;
		repeat (40) @(negedge clk_sys_in);
		n = aort_link_sink_inst.words.size();
		// fifo depth plus the registered link word survive the stall
		chk("drained", 48'(aort_pkg::FIFO_DEPTH + 1), 48'(n));
		chk("link idle", 48'h0, 48'(link_valid_out));
		give_verdict();
	end
endmodule
